// *** rtl/nmt_pkg.sv ***
package nmt_pkg;

  // ****************************
  // node and entry numbering
  // ****************************
  localparam int         NODES    = 127;
  localparam int         ALL_SUB  = 128;
  localparam logic [7:0] SUB_ALL  = 8'h80;
  localparam logic [7:0] SUB_LAST = 8'h7F;

  // ****************************
  // register map
  // ****************************
  localparam int         ADR_W      = 13;
  localparam int         RGN_LSB    = 10;
  localparam int         SUB_LSB    = 2;
  localparam logic [2:0] RGN_REQ    = 3'h0;
  localparam logic [2:0] RGN_GUARD  = 3'h1;
  localparam logic [2:0] RGN_ASSIGN = 3'h2;
  localparam logic [2:0] RGN_DTYPE  = 3'h3;
  localparam logic [2:0] RGN_VEND   = 3'h4;
  localparam logic [2:0] RGN_HB     = 3'h5;
  localparam logic [2:0] RGN_CTRL   = 3'h6;
  localparam logic [7:0] SUB_CTRL   = 8'h00;
  localparam logic [7:0] SUB_STAT   = 8'h01;
  localparam int         MASTER_BIT = 0;
  localparam logic       MASTER_RST = 1'b0;

  // ****************************
  // request and state codes
  // ****************************
  localparam logic [6:0] CODE_UNKNOWN  = 7'h00;
  localparam logic [6:0] CODE_MISSING  = 7'h01;
  localparam logic [6:0] CODE_STOP     = 7'h04;
  localparam logic [6:0] CODE_START    = 7'h05;
  localparam logic [6:0] CODE_RST_NODE = 7'h06;
  localparam logic [6:0] CODE_RST_COMM = 7'h07;
  localparam logic [6:0] CODE_PREOP    = 7'h7F;

  // ****************************
  // slave assignment word fields
  // ****************************
  localparam int ASG_SLV     = 0;
  localparam int ASG_MAND    = 3;
  localparam int ASG_RTY_LSB = 8;
  localparam int RTY_W       = 8;
  localparam int ASG_IVL_LSB = 16;
  localparam int IVL_W       = 16;

  // ****************************
  // timing
  // ****************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************
  // carriers
  // ****************************
  typedef struct packed {logic valid; logic [6:0] node; logic [6:0] code;} nmt_cmd_type;
  typedef struct packed {logic valid; logic [6:0] node;} poll_type;
  typedef struct packed {logic valid; logic [6:0] node; logic [6:0] state;} mon_type;
  typedef struct packed {
    logic        valid;
    logic [6:0]  node;
    logic        present;
    logic [31:0] dev_type;
    logic [31:0] vendor;
  } ident_type;
  typedef struct packed {logic valid; logic [6:0] node; logic ok;} boot_type;

endpackage

// *** rtl/boot_check.sv ***
`timescale 1ns/1ps
module boot_check import nmt_pkg::*; (
  input  wire logic        mandatory_i,  // slave marked mandatory
  input  wire logic        present_i,    // node answered
  input  wire logic [31:0] exp_type_i,   // expected device type
  input  wire logic [31:0] got_type_i,   // device type read from node
  input  wire logic [31:0] exp_vendor_i, // expected vendor
  input  wire logic [31:0] got_vendor_i, // vendor read from node
  output logic             ok_o          // boot may continue
);
  wire check_w  = exp_type_i != 32'h0 || mandatory_i;
  wire type_ok  = !check_w || (present_i &&
                  (exp_type_i == 32'h0 || got_type_i == exp_type_i));
  wire vend_ok  = present_i && got_vendor_i == exp_vendor_i;
  assign ok_o   = type_ok && vend_ok;
endmodule

// *** rtl/guard_timer.sv ***
`timescale 1ns/1ps
module guard_timer import nmt_pkg::*; (
  input  wire logic             clk_i,            // clock
  input  wire logic             rst_b_i,          // async reset, active low
  input  wire logic             ms_tick_i,        // one pulse per millisecond
  input  wire logic             run_i,            // guarding requested
  input  wire logic [IVL_W-1:0] guard_interval_i, // ms between polls
  input  wire logic [RTY_W-1:0] retry_count_i,    // polls before failure
  input  wire logic             taken_i,          // poll handed to link
  input  wire logic             answer_i,         // node answered
  output logic                  poll_o,           // poll wanted
  output logic                  fail_o            // node missing
);
  logic [IVL_W-1:0] cnt_q;
  logic [RTY_W-1:0] miss_q;
  logic             wait_q;
  logic             fail_q;

  wire active_w = run_i && guard_interval_i != '0 && retry_count_i != '0;
  wire expire_w = ms_tick_i && cnt_q <= IVL_W'(1);
  wire last_w   = miss_q + RTY_W'(1) == retry_count_i;
  // no fresh poll once the retries are used up
  wire miss_w   = expire_w && wait_q && !fail_q && !answer_i;
  wire repoll_w = expire_w && !fail_q && !(miss_w && last_w);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      miss_q <= '0;
      wait_q <= 1'b0;
      poll_o <= 1'b0;
      fail_q <= 1'b0;
    end else if (!active_w) begin
      cnt_q  <= guard_interval_i;
      miss_q <= '0;
      wait_q <= 1'b0;
      poll_o <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (ms_tick_i) begin
        cnt_q <= expire_w ? guard_interval_i : cnt_q - IVL_W'(1);
      end
      if (answer_i) begin
        miss_q <= '0;
        fail_q <= 1'b0;
      end else if (expire_w && wait_q && !fail_q) begin
        miss_q <= miss_q + RTY_W'(1);
        fail_q <= last_w;
      end
      if (repoll_w) begin
        poll_o <= 1'b1;
        wait_q <= !answer_i;
      end else begin
        if (taken_i) begin
          poll_o <= 1'b0;
        end
        if (answer_i) begin
          wait_q <= 1'b0;
        end
      end
    end
  end

  assign fail_o = fail_q;

  property p_idle;
    @(posedge clk_i) disable iff (!rst_b_i) !active_w |=> !poll_o && !fail_o;
  endproperty
  a_idle: assert property (p_idle) else $error("guard active without interval or retries");

  property p_fail;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(fail_q) |-> $past(miss_q) + RTY_W'(1) == $past(retry_count_i);
  endproperty
  a_fail: assert property (p_fail) else $error("failure after wrong number of polls");
endmodule

// *** rtl/nmt_master.sv ***
`timescale 1ns/1ps
// Operation
// - node entry targets one node, 128 all
// - write 4 stop,5 start,6/7 resets,127 preop
// - read 0 when node unconfigured or unmonitored
// - read 1 when guarding of node failed
// - read monitored state as 4, 5, 127
// - clear stored request once command sent
// - request entry zero reads 128
// - guard entry: write 1 start, 0 stop
// - guard entry 128 write-only, acts on all
// - guard uses assignment, not with heartbeat
// - guarding honoured only as network master
// - assignment: interval 31-16, retries 15-8, flags
// - unanswered poll repeated retries minus one times
// - check type if nonzero or mandatory
// - expected type zero checks existence only
// - type mismatch blocks node start of slave, not network start
// - vendor mismatch blocks node start of slave, not network start
// - type and vendor entry zero read 127
// - guard only with nonzero interval and retries
// - no network start while mandatory node missing
module nmt_master import nmt_pkg::*; #(
  parameter int MS_TICKS = MS_CYCLES          // clock cycles per millisecond
) (
  input  wire logic             clk_i,        // clock, 50 MHz
  input  wire logic             rst_b_i,      // async reset, active low
  input  wire logic             cyc_i,        // wishbone cycle
  input  wire logic             stb_i,        // wishbone strobe
  input  wire logic             we_i,         // wishbone write
  input  wire logic [ADR_W-1:0] adr_i,        // wishbone byte address
  input  wire logic [3:0]       sel_i,        // wishbone byte enables
  input  wire logic [31:0]      dat_i,        // wishbone write data
  output logic      [31:0]      dat_o,        // wishbone read data
  output logic                  ack_o,        // wishbone acknowledge
  output nmt_cmd_type           nmt_o,        // nmt service to link
  input  wire logic             nmt_ready_i,  // link took service
  output poll_type              poll_o,       // guard poll to link
  input  wire logic             poll_ready_i, // link took poll
  input  wire mon_type          mon_i,        // state seen from a node
  input  wire ident_type        ident_i,      // identity read at boot
  output boot_type              boot_o        // boot check result
);
  localparam int MS_W = $clog2(MS_TICKS);

  // ****************************
  // helpers
  // ****************************
  function automatic logic is_write_code(input logic [6:0] v);
    is_write_code = v == CODE_STOP || v == CODE_START || v == CODE_RST_NODE ||
                    v == CODE_RST_COMM || v == CODE_PREOP;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // ****************************
  // state
  // ****************************
  logic [6:0]      req_q   [1:ALL_SUB];
  logic [31:0]     asg_q   [1:NODES];
  logic [31:0]     dtype_q [1:NODES];
  logic [31:0]     vend_q  [1:NODES];
  logic [6:0]      state_q [1:NODES];
  logic [NODES:1]  guard_q;
  logic [NODES:1]  hb_q;
  logic [NODES:1]  hold_q;
  logic [NODES:1]  mmiss_q;
  logic            master_q;
  logic            ack_q;
  logic [31:0]     dat_q;
  logic [7:0]      rptr_q;
  logic [7:0]      sent_q;
  logic [6:0]      pptr_q;
  logic [MS_W-1:0] msdiv_q;
  logic            ms_q;
  nmt_cmd_type     nmt_q;
  poll_type        poll_q;
  boot_type        boot_q;

  wire [NODES:1] poll_w;
  wire [NODES:1] fail_w;
  wire [NODES:1] run_w;
  wire [NODES:1] ans_w;
  wire [NODES:1] take_w;
  wire           chk_ok_w;

  // ****************************
  // bus decode
  // ****************************
  wire [2:0] rgn_w   = adr_i[RGN_LSB +: 3];
  wire [7:0] sub_w   = adr_i[SUB_LSB +: 8];
  wire [6:0] nd_w    = sub_w[6:0];
  wire       sub0_w  = sub_w == 8'h00;
  wire       node_w  = !sub0_w && sub_w <= SUB_LAST;
  wire       all_w   = sub_w == SUB_ALL;
  wire       hit_w   = cyc_i && stb_i && !ack_q;
  wire       wr_w    = cyc_i && stb_i && we_i && ack_q;
  wire       wnode_w = wr_w && node_w;
  wire       wreq_w  = wr_w && rgn_w == RGN_REQ && sel_i[0] && (node_w || all_w) &&
                       dat_i[31:7] == 25'h0 && is_write_code(dat_i[6:0]);
  wire       wgrd_w  = wr_w && rgn_w == RGN_GUARD && sel_i[0] && master_q;
  wire [6:0] req_rd_w = req_q[sub_w];

  // ****************************
  // read selection
  // ****************************
  wire       mon_act_w = guard_q[nd_w] || hb_q[nd_w];
  wire [6:0] ncode_w   = !asg_q[nd_w][ASG_SLV] || !mon_act_w ? CODE_UNKNOWN :
                         fail_w[nd_w] ? CODE_MISSING :
                         state_q[nd_w];
  wire [31:0] ctrl_rd_w = sub_w == SUB_CTRL ? {31'h0, master_q} :
                          sub_w == SUB_STAT ? {30'h0, nmt_q.valid, |mmiss_q} : 32'h0;
  wire [31:0] rd_w =
    rgn_w == RGN_CTRL   ? ctrl_rd_w :
    !(node_w || sub0_w) ? 32'h0 :
    rgn_w == RGN_REQ    ? (sub0_w ? {24'h0, SUB_ALL} : {25'h0, ncode_w}) :
    rgn_w == RGN_GUARD  ? (sub0_w ? {24'h0, SUB_ALL} : {31'h0, guard_q[nd_w]}) :
    rgn_w == RGN_ASSIGN ? (sub0_w ? {24'h0, SUB_LAST} : asg_q[nd_w]) :
    rgn_w == RGN_DTYPE  ? (sub0_w ? {24'h0, SUB_LAST} : dtype_q[nd_w]) :
    rgn_w == RGN_VEND   ? (sub0_w ? {24'h0, SUB_LAST} : vend_q[nd_w]) :
    rgn_w == RGN_HB     ? (sub0_w ? 32'h0 : {31'h0, hb_q[nd_w]}) : 32'h0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= hit_w;
      dat_q <= hit_w && !we_i ? rd_w : 32'h0;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ****************************
  // configuration
  // ****************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 1; i <= NODES; i++) begin
        asg_q[i]   <= 32'h0;
        dtype_q[i] <= 32'h0;
        vend_q[i]  <= 32'h0;
      end
      hb_q     <= '0;
      master_q <= MASTER_RST;
    end else begin
      if (wnode_w && rgn_w == RGN_ASSIGN) begin
        asg_q[nd_w] <= merge(asg_q[nd_w], dat_i, sel_i);
      end
      if (wnode_w && rgn_w == RGN_DTYPE) begin
        dtype_q[nd_w] <= merge(dtype_q[nd_w], dat_i, sel_i);
      end
      if (wnode_w && rgn_w == RGN_VEND) begin
        vend_q[nd_w] <= merge(vend_q[nd_w], dat_i, sel_i);
      end
      if (wnode_w && rgn_w == RGN_HB && sel_i[0]) begin
        hb_q[nd_w] <= dat_i[0];
      end
      if (wr_w && rgn_w == RGN_CTRL && sub_w == SUB_CTRL && sel_i[0]) begin
        master_q <= dat_i[MASTER_BIT];
      end
    end
  end

  // ****************************
  // guarding requests
  // ****************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      guard_q <= '0;
    end else begin
      for (int i = 1; i <= NODES; i++) begin
        if (wgrd_w && (all_w || (node_w && nd_w == 7'(i))) && !hb_q[i]) begin
          guard_q[i] <= dat_i[0];
        end
      end
    end
  end

  // ****************************
  // request store and nmt sender
  // ****************************
  wire [6:0] pend_w   = req_q[rptr_q];
  wire       bcast_w  = rptr_q == SUB_ALL;
  wire       drop_w   = pend_w == CODE_START && (bcast_w ? |mmiss_q : hold_q[rptr_q[6:0]]);
  wire       scan_w   = !nmt_q.valid && pend_w != CODE_UNKNOWN;
  wire       launch_w = scan_w && !drop_w;
  wire       dropn_w  = scan_w && drop_w;
  wire       done_w   = nmt_q.valid && nmt_ready_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 1; i <= ALL_SUB; i++) begin
        req_q[i] <= CODE_UNKNOWN;
      end
    end else begin
      if (done_w) begin
        req_q[sent_q] <= CODE_UNKNOWN;
      end
      if (dropn_w) begin
        req_q[rptr_q] <= CODE_UNKNOWN;
      end
      if (wreq_w) begin
        req_q[sub_w] <= dat_i[6:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rptr_q <= 8'h01;
      sent_q <= 8'h01;
      nmt_q  <= '0;
    end else begin
      if (!nmt_q.valid) begin
        rptr_q <= bcast_w ? 8'h01 : rptr_q + 8'h01;
      end
      if (launch_w) begin
        nmt_q.valid <= 1'b1;
        nmt_q.node  <= bcast_w ? 7'h00 : rptr_q[6:0];
        nmt_q.code  <= pend_w;
        sent_q      <= rptr_q;
      end else if (done_w) begin
        nmt_q.valid <= 1'b0;
      end
    end
  end

  assign nmt_o = nmt_q;

  // ****************************
  // guard timers and poll arbiter
  // ****************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msdiv_q <= '0;
      ms_q    <= 1'b0;
    end else if (msdiv_q == MS_W'(MS_TICKS - 1)) begin
      msdiv_q <= '0;
      ms_q    <= 1'b1;
    end else begin
      msdiv_q <= msdiv_q + MS_W'(1);
      ms_q    <= 1'b0;
    end
  end

  wire plaunch_w = !poll_q.valid && poll_w[pptr_q];

  for (genvar g = 1; g <= NODES; g++) begin : g_guard
    assign run_w[g]  = guard_q[g] && master_q && !hb_q[g] && asg_q[g][ASG_SLV];
    assign ans_w[g]  = mon_i.valid && mon_i.node == 7'(g);
    assign take_w[g] = plaunch_w && pptr_q == 7'(g);
    guard_timer u_timer (
      .clk_i            (clk_i),
      .rst_b_i          (rst_b_i),
      .ms_tick_i        (ms_q),
      .run_i            (run_w[g]),
      .guard_interval_i (asg_q[g][ASG_IVL_LSB +: IVL_W]),
      .retry_count_i    (asg_q[g][ASG_RTY_LSB +: RTY_W]),
      .taken_i          (take_w[g]),
      .answer_i         (ans_w[g]),
      .poll_o           (poll_w[g]),
      .fail_o           (fail_w[g])
    );
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pptr_q <= 7'h01;
      poll_q <= '0;
    end else begin
      if (!poll_q.valid) begin
        pptr_q <= pptr_q == SUB_LAST[6:0] ? 7'h01 : pptr_q + 7'h01;
      end
      if (plaunch_w) begin
        poll_q <= '{valid: 1'b1, node: pptr_q};
      end else if (poll_q.valid && poll_ready_i) begin
        poll_q.valid <= 1'b0;
      end
    end
  end

  assign poll_o = poll_q;

  // ****************************
  // node state and boot checks
  // ****************************
  wire [6:0] in_w    = ident_i.node;
  wire       id_ok_w = ident_i.valid && in_w != 7'h00;

  boot_check u_check (
    .mandatory_i  (asg_q[in_w][ASG_MAND]),
    .present_i    (ident_i.present),
    .exp_type_i   (dtype_q[in_w]),
    .got_type_i   (ident_i.dev_type),
    .exp_vendor_i (vend_q[in_w]),
    .got_vendor_i (ident_i.vendor),
    .ok_o         (chk_ok_w)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 1; i <= NODES; i++) begin
        state_q[i] <= CODE_UNKNOWN;
      end
      hold_q  <= '0;
      mmiss_q <= '0;
      boot_q  <= '0;
    end else begin
      if (mon_i.valid && mon_i.node != 7'h00) begin
        state_q[mon_i.node] <= mon_i.state;
      end
      boot_q <= '{valid: id_ok_w, node: in_w, ok: id_ok_w && chk_ok_w};
      if (id_ok_w) begin
        hold_q[in_w]  <= !chk_ok_w;
        mmiss_q[in_w] <= asg_q[in_w][ASG_MAND] && !ident_i.present;
      end
    end
  end

  assign boot_o = boot_q;

  // ****************************
  // checks
  // ****************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_sub0_req;
    ack_q && !we_i && rgn_w == RGN_REQ && sub0_w |-> dat_q == 32'h80;
  endproperty
  a_sub0_req: assert property (p_sub0_req) else $error("request entry zero not 128");

  property p_sub0_id;
    ack_q && !we_i && (rgn_w == RGN_DTYPE || rgn_w == RGN_VEND) && sub0_w |-> dat_q == 32'h7F;
  endproperty
  a_sub0_id: assert property (p_sub0_id) else $error("identity entry zero not 127");

  property p_unknown;
    hit_w && !we_i && rgn_w == RGN_REQ && node_w && !asg_q[nd_w][ASG_SLV] |=> dat_q == 32'h0;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unconfigured node not read as 0");

  property p_missing;
    hit_w && !we_i && rgn_w == RGN_REQ && node_w && asg_q[nd_w][ASG_SLV] && guard_q[nd_w] &&
      fail_w[nd_w] |=> dat_q == 32'h1;
  endproperty
  a_missing: assert property (p_missing) else $error("failed node not read as 1");

  property p_state;
    hit_w && !we_i && rgn_w == RGN_REQ && node_w && asg_q[nd_w][ASG_SLV] && mon_act_w &&
      !fail_w[nd_w] |=> dat_q[6:0] == $past(state_q[nd_w]);
  endproperty
  a_state: assert property (p_state) else $error("monitored state not reported");

  property p_clear;
    done_w && !(wreq_w && sub_w == sent_q) |=> req_q[$past(sent_q)] == CODE_UNKNOWN;
  endproperty
  a_clear: assert property (p_clear) else $error("request kept after send");

  property p_ignore;
    wr_w && rgn_w == RGN_REQ && (node_w || all_w) && !is_write_code(dat_i[6:0]) && !done_w &&
      !dropn_w |=> req_q[$past(sub_w)] == $past(req_rd_w);
  endproperty
  a_ignore: assert property (p_ignore) else $error("undefined request stored");

  property p_bcast;
    launch_w |=> nmt_q.valid && nmt_q.node == ($past(bcast_w) ? 7'h00 : $past(rptr_q[6:0]));
  endproperty
  a_bcast: assert property (p_bcast) else $error("service sent to wrong node");

  property p_code;
    nmt_q.valid |-> is_write_code(nmt_q.code);
  endproperty
  a_code: assert property (p_code) else $error("undefined service sent");

  property p_master;
    wr_w && rgn_w == RGN_GUARD && !master_q |=> $stable(guard_q);
  endproperty
  a_master: assert property (p_master) else $error("guard changed outside master mode");

  property p_hb;
    wr_w && rgn_w == RGN_GUARD && node_w && hb_q[nd_w] |=> guard_q[$past(nd_w)] == $past(guard_q[nd_w]);
  endproperty
  a_hb: assert property (p_hb) else $error("guard started beside heartbeat");

  property p_no_start;
    !nmt_q.valid ##1 nmt_q.valid && nmt_q.node == 7'h00 && nmt_q.code == CODE_START |->
      $past(mmiss_q) == '0;
  endproperty
  a_no_start: assert property (p_no_start) else $error("network started with node missing");

  property p_hold;
    id_ok_w && !chk_ok_w |=> boot_o.valid && !boot_o.ok && hold_q[$past(in_w)];
  endproperty
  a_hold: assert property (p_hold) else $error("mismatched slave not held");

  c_sent: cover property (done_w);
  c_bcast: cover property (launch_w && bcast_w);
  c_boot_fail: cover property (boot_o.valid && !boot_o.ok);
  c_guard_fail: cover property (|fail_w);
endmodule

// *** verif/link_model.sv ***
`timescale 1ns/1ps
module link_model import nmt_pkg::*; (
  input  wire logic clk_i,        // clock
  input  wire logic rst_b_i,      // async reset, active low
  input  wire logic nmt_valid_i,  // service offered
  input  wire logic poll_valid_i, // poll offered
  output logic      nmt_ready_o,  // service taken
  output logic      poll_ready_o  // poll taken
);
  // ********************
  // link acceptance, services stall at random, polls taken next cycle
  // ********************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmt_ready_o  <= 1'b0;
      poll_ready_o <= 1'b0;
    end else begin
      nmt_ready_o  <= nmt_valid_i && ($urandom % 3 == 0);
      poll_ready_o <= poll_valid_i;
    end
  end
endmodule

// *** verif/canopen_nmt_master_requests_tb.sv ***
`timescale 1ns/1ps
module canopen_nmt_master_requests_tb import nmt_pkg::*; ;
  logic             clk_i = 1'b0, rst_b_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0]       sel_i = '0;
  logic [31:0]      dat_i = '0, dat_o, rd, et, ev;
  logic             ack_o, nmt_ready_i, poll_ready_i;
  nmt_cmd_type      nmt_o;
  poll_type         poll_o;
  mon_type          mon_i = '0;
  ident_type        ident_i = '0;
  boot_type         boot_o;
  int               n_errors = 0, n_compared = 0, n_sent = 0, k, n_polls = 0, n_base;
  int               exp_q[$];
  int               codes[5] = '{4, 5, 6, 7, 127};

  nmt_master #(.MS_TICKS(200)) nmt_master_i (.clk_i, .rst_b_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .nmt_o, .nmt_ready_i, .poll_o, .poll_ready_i,
    .mon_i, .ident_i, .boot_o);
  link_model link_model_i (.clk_i, .rst_b_i, .nmt_valid_i(nmt_o.valid),
    .poll_valid_i(poll_o.valid), .nmt_ready_o(nmt_ready_i), .poll_ready_o(poll_ready_i));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang;
    n_errors++;
    $display("Error %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic wb(input logic w, input logic [2:0] r, input logic [7:0] s, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hF;
    adr_i <= {r, s, 2'b00};
    dat_i <= d;
    for (k = 0; k < 50 && ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 50) hang();
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [2:0] r, input logic [7:0] s, input logic [31:0] exp);
    wb(1'b0, r, s, '0);
    chk(rd, exp);
  endtask

  // model: queue of expected services, node 0 for all
  task automatic req(input int n, input int c);
    wb(1'b1, RGN_REQ, 8'(n), 32'(c));
    if (c inside {4, 5, 6, 7, 127}) exp_q.push_back(((n % 128) << 7) | c);
    for (k = 0; k < 600 && exp_q.size() > 0; k++) @(posedge clk_i);
    if (exp_q.size() > 0) hang();
  endtask

  task automatic mon(input logic [6:0] s);
    mon_i <= '{1'b1, 7'd5, s};
    @(posedge clk_i);
    mon_i <= '0;
  endtask

  task automatic boot(input logic p, input logic [31:0] t, input logic [31:0] v, input logic ok);
    ident_i <= '{1'b1, 7'd9, p, t, v};
    @(posedge clk_i);
    ident_i <= '0;
    @(posedge clk_i);
    chk({boot_o.valid, boot_o.ok}, {1'b1, ok});
  endtask

  always @(posedge clk_i) begin
    if (nmt_o.valid === 1'b1 && nmt_ready_i === 1'b1) begin
      n_sent++;
      chk({18'h0, nmt_o.node, nmt_o.code}, exp_q.pop_front());
    end
    if (poll_o.valid === 1'b1 && poll_ready_i === 1'b1) begin
      n_polls++;
      chk(poll_o.node, 5);
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'hCE53AC4C));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rdchk(RGN_REQ, 8'h00, 128);
    rdchk(RGN_DTYPE, 8'h00, 127);
    rdchk(RGN_VEND, 8'h00, 127);
    foreach (codes[i]) req(5, codes[i]);
    req(128, 127);
    req(5, 1);
    repeat (200) @(posedge clk_i);
    chk(n_sent, 6);
    rdchk(RGN_REQ, 8'h05, 0);
    $display("request test done");
    wb(1'b1, RGN_ASSIGN, 8'h05, 32'h0001_0301);
    wb(1'b1, RGN_GUARD, 8'h05, 1);
    rdchk(RGN_GUARD, 8'h05, 0);
    wb(1'b1, RGN_CTRL, SUB_CTRL, 1);
    wb(1'b1, RGN_GUARD, 8'h05, 1);
    rdchk(RGN_GUARD, 8'h05, 1);
    mon(7'h7F);
    rdchk(RGN_REQ, 8'h05, 127);
    for (int i = 0; i < 500 && rd !== 32'h1; i++) wb(1'b0, RGN_REQ, 8'h05, '0);
    chk(rd, 1);
    chk(n_polls >= 3, 1);
    n_base = n_polls;
    repeat (600) @(posedge clk_i);
    chk(n_polls, n_base);
    mon(7'h05);
    rdchk(RGN_REQ, 8'h05, 5);
    wb(1'b1, RGN_GUARD, 8'h05, 0);
    wb(1'b1, RGN_HB, 8'h05, 1);
    wb(1'b1, RGN_GUARD, 8'h05, 1);
    rdchk(RGN_GUARD, 8'h05, 0);
    wb(1'b1, RGN_HB, 8'h05, 0);
    wb(1'b1, RGN_GUARD, 8'h80, 1);
    rdchk(RGN_GUARD, 8'h05, 1);
    wb(1'b1, RGN_GUARD, 8'h80, 0);
    rdchk(RGN_GUARD, 8'h05, 0);
    $display("guard test done");
    et = $urandom | 32'h1;
    ev = $urandom;
    wb(1'b1, RGN_ASSIGN, 8'h09, 32'h0000_0009);
    wb(1'b1, RGN_DTYPE, 8'h09, et);
    wb(1'b1, RGN_VEND, 8'h09, ev);
    boot(1'b1, et, ev, 1'b1);
    boot(1'b1, et ^ 32'h2, ev, 1'b0);
    boot(1'b1, et, ev + 32'h1, 1'b0);
    wb(1'b1, RGN_DTYPE, 8'h09, 0);
    boot(1'b1, $urandom, ev, 1'b1);
    boot(1'b0, 0, ev, 1'b0);
    rdchk(RGN_CTRL, SUB_STAT, 1);
    req(128, 0);
    wb(1'b1, RGN_REQ, 8'h80, 5);
    wb(1'b1, RGN_REQ, 8'h09, 5);
    repeat (200) @(posedge clk_i);
    chk(n_sent, 6);
    $display("boot test done");
    report_and_stop();
  end
endmodule
